// ---- ebu_bus_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ebu_params.svh"


module ebu_bus_unit import ebu_pkg::*; (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // core request port
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire ebu_kind_t req_kind_i,
    input wire logic [`EBU_ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_be_n_i,
    input wire logic [`EBU_DATA_W-1:0] req_wdata_i,
    input wire logic req_lock_i,
    input wire logic req_local_i,
    // read data to the core
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [`EBU_DATA_W-1:0] rd_data_o,
    // internal masters
    input wire logic dma0_req_i,
    input wire logic dma1_req_i,
    input wire logic ref_req_i,
    output logic dma0_gnt_o,
    output logic dma1_gnt_o,
    output logic ref_gnt_o,
    // address and status pins
    output logic [`EBU_ADDR_W-1:0] addr_o,
    output logic high_byte_en_n_o,
    output logic low_byte_en_n_o,
    output logic addr_strobe_n_o,
    output logic write_not_read_o,
    output logic mem_not_io_o,
    output logic data_not_ctrl_o,
    output logic lock_n_o,
    output logic local_access_n_o,
    output logic refresh_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic bus_oe_n_o,
    // data bus pins
    output logic [`EBU_DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    input wire logic [`EBU_DATA_W-1:0] data_i,
    // cycle control pins
    input wire logic ready_n_i,
    input wire logic next_addr_req_n_i,
    input wire logic narrow_bus_n_i,
    // external master pins
    input wire logic hold_i,
    output logic bus_grant_out_o
);

    // ============================================================
    // pin synchronisers
    logic [`EBU_SYNC_W-1:0] meta_ff, sync_ff;
    logic ready_prev_ff;
    wire [`EBU_SYNC_W-1:0] pin_raw = {data_i, ready_n_i, next_addr_req_n_i,
                                      narrow_bus_n_i, hold_i};
    wire [`EBU_DATA_W-1:0] data_s = sync_ff[19:4];
    wire ready_s = !sync_ff[3];
    wire na_s = !sync_ff[2];
    wire narrow_s = !sync_ff[1];
    wire hold_s = sync_ff[0];
    // edge, so a completion held over from the last cycle is not reused
    wire ready_rise = ready_s && !ready_prev_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff <= 20'h0000e; // idle pin levels, no false ready edge
            sync_ff <= 20'h0000e;
            ready_prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
            ready_prev_ff <= ready_s;
        end
    end

    // ============================================================
    // state
    ebu_state_t state_ff, nxt_state;
    ebu_kind_t cur_kind_ff, pend_kind_ff;
    logic [`EBU_ADDR_W-1:0] cur_addr_ff;
    logic [`EBU_DATA_W-1:0] cur_wdata_ff, pend_wdata_ff;
    logic [1:0] cur_be_ff;
    logic cur_lock_ff, cur_local_ff, half_ff;
    logic pend_ff, pend_local_ff, pend_lock_ff;
    logic [1:0] pend_be_ff;
    logic lock_seq_ff;
    logic [7:0] rd_lo_ff;
    // pin registers
    logic [`EBU_ADDR_W-1:0] addr_ff;
    logic [1:0] be_n_ff;
    logic [2:0] status_ff;
    logic ads_n_ff, lock_n_ff, refresh_n_ff;
    logic [`EBU_DATA_W-1:0] data_ff;

    logic core_hold, buf_in_ready;
    logic [1:0] buf_cnt;

    // ============================================================
    // cycle decode
    wire busy = (state_ff == EBU_S_T1) || (state_ff == EBU_S_T2);
    wire done = (state_ff == EBU_S_T2) && (cur_local_ff || ready_rise);
    wire split = done && narrow_s && !half_ff &&
                 (cur_be_ff == `EBU_BE_WORD) && (cur_kind_ff != EBU_REFRESH);
    wire fin = done && !split;
    wire na_take = (state_ff == EBU_S_T2) && !done && na_s && !pend_ff;
    // release only between cycles of an unlocked sequence
    wire lock_eff = busy ? cur_lock_ff : lock_seq_ff;
    wire hold_block = core_hold && !lock_eff;
    wire slot = ((state_ff == EBU_S_IDLE) || (fin && !pend_ff) || na_take) &&
                !hold_block;
    // reads in flight must fit the buffer, so no word is ever dropped
    wire [1:0] reads_out = 2'(busy && ebu_is_read(cur_kind_ff)) +
                           2'(pend_ff && ebu_is_read(pend_kind_ff));
    wire buf_ok = !ebu_is_read(req_kind_i) ||
                  ((3'(buf_cnt) + 3'(reads_out)) < 3'(`EBU_BUF_DEPTH));
    assign req_ready_o = slot && buf_ok;
    wire fire = req_valid_i && req_ready_o;
    wire to_pend = fire && na_take;
    wire to_cur = (fire && !na_take) || (fin && pend_ff);
    wire core_bus_grant_out = (state_ff == EBU_S_HOLD);

    // incoming cycle for the current slot: pending one first
    wire ebu_kind_t in_kind = pend_ff ? pend_kind_ff : req_kind_i;
    wire [`EBU_DATA_W-1:0] in_wdata = pend_ff ? pend_wdata_ff : req_wdata_i;
    wire [1:0] req_be = (req_kind_i == EBU_REFRESH) ? `EBU_BE_REFRESH
                                                    : req_be_n_i;
    wire [1:0] in_be = pend_ff ? pend_be_ff : req_be;

    // ============================================================
    // read data assembly and capture at completion
    wire rd_push = fin && ebu_is_read(cur_kind_ff);
    wire narrow_hi = narrow_s && (cur_be_ff == `EBU_BE_HIGH);
    // a narrow device always answers on the low lane
    wire [`EBU_DATA_W-1:0] rd_word = half_ff ? {data_s[7:0], rd_lo_ff} :
                                     narrow_hi ? {data_s[7:0], data_s[7:0]} :
                                     data_s;

    // ============================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            EBU_S_IDLE: begin
                if (hold_block) nxt_state = EBU_S_HOLD;
                else if (fire) nxt_state = EBU_S_T1;
            end
            EBU_S_T1: nxt_state = EBU_S_T2;
            EBU_S_T2: begin
                if (split) nxt_state = EBU_S_T1;
                else if (fin && pend_ff) nxt_state = EBU_S_T2;
                else if (fin && fire) nxt_state = EBU_S_T1;
                else if (fin) nxt_state = EBU_S_IDLE;
            end
            EBU_S_HOLD: begin
                if (!core_hold) nxt_state = EBU_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) state_ff <= EBU_S_IDLE;
        else state_ff <= nxt_state;
    end

    // ============================================================
    // current cycle registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_kind_ff <= EBU_MEM_RD;
            cur_addr_ff <= `EBU_RST_ADDR;
            cur_wdata_ff <= `EBU_RST_DATA;
            cur_be_ff <= `EBU_BE_WORD;
            cur_lock_ff <= 1'b0;
            cur_local_ff <= 1'b0;
        end else if (to_cur) begin
            cur_kind_ff <= in_kind;
            cur_addr_ff <= pend_ff ? addr_ff : req_addr_i;
            cur_wdata_ff <= in_wdata;
            cur_be_ff <= in_be;
            cur_lock_ff <= pend_ff ? pend_lock_ff : req_lock_i;
            cur_local_ff <= pend_ff ? pend_local_ff : req_local_i;
        end
    end

    // pipelined next cycle waiting behind the current one
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_ff <= 1'b0;
            pend_kind_ff <= EBU_MEM_RD;
            pend_wdata_ff <= `EBU_RST_DATA;
            pend_be_ff <= `EBU_BE_WORD;
            pend_lock_ff <= 1'b0;
            pend_local_ff <= 1'b0;
        end else if (to_pend) begin
            pend_ff <= 1'b1;
            pend_kind_ff <= req_kind_i;
            pend_wdata_ff <= req_wdata_i;
            pend_be_ff <= req_be;
            pend_lock_ff <= req_lock_i;
            pend_local_ff <= req_local_i;
        end else if (fin) begin
            pend_ff <= 1'b0;
        end
    end

    // narrow half tracking, lock sequence, low byte holding
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            half_ff <= 1'b0;
            lock_seq_ff <= 1'b0;
            rd_lo_ff <= 8'h00;
        end else begin
            if (split) half_ff <= 1'b1;
            else if (fin) half_ff <= 1'b0;
            if (fin) lock_seq_ff <= cur_lock_ff;
            if (split) rd_lo_ff <= data_s[7:0];
        end
    end

    // ============================================================
    // address and status pins; a split re-issues the current address
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_ff <= `EBU_RST_ADDR;
            be_n_ff <= `EBU_BE_REFRESH;
            status_ff <= 3'h0;
            ads_n_ff <= 1'b1;
            lock_n_ff <= 1'b1;
            refresh_n_ff <= 1'b1;
        end else begin
            ads_n_ff <= !(fire || split);
            if (split) begin
                addr_ff <= cur_addr_ff;
                be_n_ff <= `EBU_BE_HIGH;
                status_ff <= ebu_status(cur_kind_ff);
            end else if (fire) begin
                addr_ff <= req_addr_i;
                be_n_ff <= req_be;
                status_ff <= ebu_status(req_kind_i);
                lock_n_ff <= !req_lock_i;
                refresh_n_ff <= (req_kind_i != EBU_REFRESH);
            end
        end
    end

    // write data lane: high byte mirrored low for narrow devices
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) data_ff <= `EBU_RST_DATA;
        else if (split) data_ff <= {2{cur_wdata_ff[15:8]}};
        else if (to_cur && in_be == `EBU_BE_HIGH)
            data_ff <= {2{in_wdata[15:8]}};
        else if (to_cur) data_ff <= in_wdata;
    end

    // ============================================================
    // pin drive
    assign addr_o = addr_ff;
    assign high_byte_en_n_o = be_n_ff[1];
    assign low_byte_en_n_o = be_n_ff[0];
    assign addr_strobe_n_o = ads_n_ff;
    assign mem_not_io_o = status_ff[2];
    assign data_not_ctrl_o = status_ff[1];
    assign write_not_read_o = status_ff[0];
    assign lock_n_o = lock_n_ff;
    assign refresh_n_o = refresh_n_ff;
    assign data_o = data_ff;
    // strobes from state flops, no decode of pins
    assign wr_n_o = !(state_ff == EBU_S_T2 && ebu_is_write(cur_kind_ff));
    assign rd_n_o = !(state_ff == EBU_S_T2 && ebu_is_read(cur_kind_ff));
    assign local_access_n_o = !(state_ff == EBU_S_T2 && cur_local_ff);
    assign data_oe_n_o = !(busy && ebu_is_write(cur_kind_ff));
    assign bus_oe_n_o = core_bus_grant_out;

    // ============================================================
    // arbiter and read buffer
    ebu_arbiter u_arb (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .hold_i(hold_s),
        .dma0_req_i(dma0_req_i),
        .dma1_req_i(dma1_req_i),
        .ref_req_i(ref_req_i),
        .core_hold_o(core_hold),
        .core_bus_grant_out_i(core_bus_grant_out),
        .bus_grant_out_o(bus_grant_out_o),
        .dma0_gnt_o(dma0_gnt_o),
        .dma1_gnt_o(dma1_gnt_o),
        .ref_gnt_o(ref_gnt_o)
    );

    ebu_buf2 u_rdbuf (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_valid_i(rd_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(rd_word),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o),
        .count_o(buf_cnt)
    );

    // ============================================================
    // checks
    AST_ADS_ONE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !addr_strobe_n_o |=> addr_strobe_n_o)
        else $error("address strobe longer than one cycle");
    AST_REFRESH_BE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !refresh_n_o |-> high_byte_en_n_o && low_byte_en_n_o)
        else $error("refresh without both byte enables high");
    AST_WR_DRIVE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !wr_n_o |-> !data_oe_n_o && bus_oe_n_o == 1'b0)
        else $error("write strobe without driven data");
    AST_STROBE_EXCL: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) !(!wr_n_o && !rd_n_o))
        else $error("read and write strobes together");
    AST_LOCAL_END: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) !local_access_n_o && !pend_ff && !split
        |=> state_ff != EBU_S_T2)
        else $error("local cycle did not end in one state");
    AST_SPLIT_HIGH: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) split |=> !addr_strobe_n_o &&
        !high_byte_en_n_o && low_byte_en_n_o ##1 !rd_n_o || !wr_n_o)
        else $error("narrow split did not start upper byte");
    AST_PIPE_ADDR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        to_pend |=> !addr_strobe_n_o && state_ff == EBU_S_T2)
        else $error("pipelined address not issued in current cycle");
    AST_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state_ff == EBU_S_IDLE && core_hold && !lock_seq_ff
        |=> state_ff == EBU_S_HOLD && bus_oe_n_o)
        else $error("core did not release idle bus");
    AST_GRANT_AFTER: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) bus_grant_out_o |-> $past(core_bus_grant_out))
        else $error("grant pin before core release");
    AST_PUSH_ROOM: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i) rd_push |-> buf_in_ready)
        else $error("read word pushed into full buffer");

endmodule // ebu_bus_unit

`default_nettype wire

// ---- ebu_params.svh ----
`ifndef EBU_PARAMS_SVH
`define EBU_PARAMS_SVH

// ============================================================
// widths
`define EBU_ADDR_W 25
`define EBU_DATA_W 16

// ============================================================
// byte-enable pair encodings, {high_n, low_n}
`define EBU_BE_WORD 2'b00
`define EBU_BE_HIGH 2'b01
`define EBU_BE_LOW 2'b10
`define EBU_BE_REFRESH 2'b11

// ============================================================
// reset values and sizes
`define EBU_RST_ADDR 25'h0000000
`define EBU_RST_DATA 16'h0000
`define EBU_BUF_DEPTH 2
`define EBU_SYNC_W 20

`endif

// ---- ebu_pkg.sv ----
`default_nettype none

package ebu_pkg;

    // ============================================================
    // cycle kinds requested by the core
    typedef enum logic [2:0] {
        EBU_MEM_RD,
        EBU_MEM_WR,
        EBU_IO_RD,
        EBU_IO_WR,
        EBU_INTA,
        EBU_HALT,
        EBU_REFRESH
    } ebu_kind_t;

    // bus state machine
    typedef enum logic [1:0] {
        EBU_S_IDLE,
        EBU_S_T1,
        EBU_S_T2,
        EBU_S_HOLD
    } ebu_state_t;

    // current bus owner seen by the arbiter
    typedef enum logic [2:0] {
        EBU_OWN_CORE,
        EBU_OWN_REF,
        EBU_OWN_DMA0,
        EBU_OWN_DMA1,
        EBU_OWN_EXT
    } ebu_owner_t;

    // ============================================================
    // kind decoding
    function automatic logic ebu_is_read(input ebu_kind_t k);
        return (k == EBU_MEM_RD) || (k == EBU_IO_RD) || (k == EBU_INTA);
    endfunction

    function automatic logic ebu_is_write(input ebu_kind_t k);
        return (k == EBU_MEM_WR) || (k == EBU_IO_WR);
    endfunction

    // status triple {mem_not_io, data_not_ctrl, write_not_read}
    function automatic logic [2:0] ebu_status(input ebu_kind_t k);
        logic [2:0] s;
        s = 3'h0;
        case (k)
            EBU_MEM_RD: s = 3'h6;
            EBU_MEM_WR: s = 3'h7;
            EBU_IO_RD: s = 3'h2;
            EBU_IO_WR: s = 3'h3;
            EBU_INTA: s = 3'h0;
            EBU_HALT: s = 3'h5;
            EBU_REFRESH: s = 3'h6;
            default: s = 3'h0;
        endcase
        return s;
    endfunction

endpackage

`default_nettype wire

// ---- ebu_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ebu_params.svh"

module ebu_buf2 (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [`EBU_DATA_W-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [`EBU_DATA_W-1:0] out_data_o,
    // fill level
    output logic [1:0] count_o
);

    // ============================================================
    // storage
    logic [`EBU_DATA_W-1:0] mem_ff [`EBU_BUF_DEPTH];
    logic wr_ptr_ff, rd_ptr_ff;
    logic [1:0] cnt_ff;

    // handshake decode
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_ff != 2'(`EBU_BUF_DEPTH));
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign count_o = cnt_ff;

    // pointers and level; data words need no reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wr_ptr_ff <= !wr_ptr_ff;
            if (pop) rd_ptr_ff <= !rd_ptr_ff;
            cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) mem_ff[wr_ptr_ff] <= in_data_i;
    end

endmodule // ebu_buf2

`default_nettype wire

// ---- ebu_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none

module ebu_arbiter import ebu_pkg::*; (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // requests
    input wire logic hold_i,
    input wire logic dma0_req_i,
    input wire logic dma1_req_i,
    input wire logic ref_req_i,
    // core handshake
    output logic core_hold_o,
    input wire logic core_bus_grant_out_i,
    // grants
    output logic bus_grant_out_o,
    output logic dma0_gnt_o,
    output logic dma1_gnt_o,
    output logic ref_gnt_o
);

    // ============================================================
    // fixed priority: refresh, dma0, dma1, external master
    ebu_owner_t owner_ff, nxt_owner, pick;
    wire any_req = hold_i || dma0_req_i || dma1_req_i || ref_req_i;
    assign pick = ref_req_i ? EBU_OWN_REF :
                  dma0_req_i ? EBU_OWN_DMA0 :
                  dma1_req_i ? EBU_OWN_DMA1 : EBU_OWN_EXT;
    wire own_req = (owner_ff == EBU_OWN_REF && ref_req_i) ||
                   (owner_ff == EBU_OWN_DMA0 && dma0_req_i) ||
                   (owner_ff == EBU_OWN_DMA1 && dma1_req_i) ||
                   (owner_ff == EBU_OWN_EXT && hold_i);

    // core stays parked while any other unit owns the bus
    assign core_hold_o = (owner_ff != EBU_OWN_CORE) || any_req;

    // owner hand-over
    always_comb begin
        nxt_owner = owner_ff;
        unique case (owner_ff)
            EBU_OWN_CORE: begin
                if (any_req && core_bus_grant_out_i) nxt_owner = pick;
            end
            EBU_OWN_REF, EBU_OWN_DMA0, EBU_OWN_DMA1, EBU_OWN_EXT: begin
                // direct hand-over, no trip through the core
                if (!own_req) nxt_owner = any_req ? pick : EBU_OWN_CORE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) owner_ff <= EBU_OWN_CORE;
        else owner_ff <= nxt_owner;
    end

    // grants straight from the owner register
    assign bus_grant_out_o = (owner_ff == EBU_OWN_EXT);
    assign dma0_gnt_o = (owner_ff == EBU_OWN_DMA0);
    assign dma1_gnt_o = (owner_ff == EBU_OWN_DMA1);
    assign ref_gnt_o = (owner_ff == EBU_OWN_REF);

    // ============================================================
    // checks
    AST_PRIO_REF: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        owner_ff == EBU_OWN_CORE && core_bus_grant_out_i && ref_req_i |=> ref_gnt_o)
        else $error("refresh not granted first");
    AST_GRANT_HELD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        bus_grant_out_o && hold_i |=> bus_grant_out_o)
        else $error("grant dropped while request held");

endmodule // ebu_arbiter

`default_nettype wire

// ---- ebu_ext_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

// far-side memory and io: answers every non-local cycle
module ebu_ext_mem (
    // bus pins seen
    input wire logic clk_sys_i,
    input wire logic addr_strobe_n_i,
    input wire logic local_access_n_i,
    input wire logic [24:0] addr_i,
    // answer pins
    output logic ready_n_o,
    output logic [15:0] data_o
);
    logic [24:0] a;
    initial begin
        ready_n_o = 1'b1;
        data_o = 16'h0000;
    end
    // ready held 4 cycles so the 2-flop sync surely sees it
    always begin
        @(posedge clk_sys_i);
        if (!addr_strobe_n_i) begin
            a = addr_i;
            @(posedge clk_sys_i);
            if (local_access_n_i) begin
                #1 ready_n_o = 1'b0;
                data_o = a[15:0] ^ 16'ha5c3;
                repeat (4) @(posedge clk_sys_i);
                #1 ready_n_o = 1'b1;
                data_o = ~data_o; // released lines lose the word
            end
        end
    end
endmodule // ebu_ext_mem

`default_nettype wire

// ---- test_external_bus_interface.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_external_bus_interface import ebu_pkg::*; ;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0;
    logic req_lock_i = 1'b0, req_local_i = 1'b0, rd_ready_i = 1'b1;
    logic hold_i = 1'b0, ready_n_i, req_ready_o, rd_valid_o;
    logic [1:0] req_be_n_i = 2'h0;
    ebu_kind_t req_kind_i = EBU_MEM_RD;
    logic [24:0] req_addr_i = 25'h0, addr_o;
    logic [15:0] req_wdata_i = 16'h0, data_i, rd_data_o, data_o;
    logic high_byte_en_n_o, low_byte_en_n_o, addr_strobe_n_o;
    logic write_not_read_o, mem_not_io_o, data_not_ctrl_o, lock_n_o;
    logic local_access_n_o, refresh_n_o, wr_n_o, rd_n_o, bus_oe_n_o;
    logic data_oe_n_o, bus_grant_out_o;
    logic [2:0] st_tab [7] = '{3'h6, 3'h7, 3'h2, 3'h3, 3'h0, 3'h5, 3'h6};
    int err_total = 0, compares = 0;

    // ============================================================
    // design and far side; internal masters stay quiet
    ebu_bus_unit i_dut (.clk_sys_i, .nrst_i, .req_valid_i, .req_ready_o,
        .req_kind_i, .req_addr_i, .req_be_n_i, .req_wdata_i,
        .req_lock_i, .req_local_i, .rd_valid_o, .rd_ready_i, .rd_data_o,
        .dma0_req_i(1'b0), .dma1_req_i(1'b0), .ref_req_i(1'b0),
        .dma0_gnt_o(), .dma1_gnt_o(), .ref_gnt_o(), .addr_o,
        .high_byte_en_n_o, .low_byte_en_n_o, .addr_strobe_n_o,
        .write_not_read_o, .mem_not_io_o, .data_not_ctrl_o, .lock_n_o,
        .local_access_n_o, .refresh_n_o, .wr_n_o, .rd_n_o, .bus_oe_n_o,
        .data_o, .data_oe_n_o, .data_i, .ready_n_i,
        .next_addr_req_n_i(1'b1), .narrow_bus_n_i(1'b1), .hold_i,
        .bus_grant_out_o);
    ebu_ext_mem i_mem (.clk_sys_i, .addr_strobe_n_i(addr_strobe_n_o),
        .local_access_n_i(local_access_n_o), .addr_i(addr_o),
        .ready_n_o(ready_n_i), .data_o(data_i));

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic chk(input string nm, input logic [24:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clk_sys_i);
        #1;
    endtask

    // one whole cycle; inputs move 1 ns after the edge
    task automatic cyc(input ebu_kind_t k, input logic lk, loc);
        int n;
        logic rd;
        logic wr;
        rd = k inside {EBU_MEM_RD, EBU_IO_RD, EBU_INTA};
        wr = k inside {EBU_MEM_WR, EBU_IO_WR};
        req_kind_i = k;
        req_addr_i = {22'h0, k} + 25'h1a5b230;
        req_wdata_i = req_addr_i[15:0] ^ 16'h0f0f;
        req_lock_i = lk;
        req_local_i = loc;
        req_valid_i = 1'b1;
        for (n = 0; n < 50 && !req_ready_o; n++) step(1);
        step(1);
        req_valid_i = 1'b0;
        chk("strobe", addr_strobe_n_o, 0);
        chk("addr", addr_o, req_addr_i);
        chk("status", {mem_not_io_o, data_not_ctrl_o, write_not_read_o},
            st_tab[k]);
        chk("be", {high_byte_en_n_o, low_byte_en_n_o},
            (k == EBU_REFRESH) ? 2'h3 : req_be_n_i);
        chk("refresh", refresh_n_o, k != EBU_REFRESH);
        chk("lock", lock_n_o, !lk);
        step(1);
        chk("lba", local_access_n_o, !loc);
        chk("rd", rd_n_o, !rd);
        chk("wr", wr_n_o, !wr);
        if (wr) chk("wdata", data_o, req_wdata_i);
        chk("wdoe", data_oe_n_o, !wr);
        for (n = 0; n < 50 && !req_ready_o; n++) step(1);
        chk("done", n < 50, 1);
        step(1);
        if (rd && !loc) begin
            chk("rvalid", rd_valid_o, 1);
            chk("rdata", rd_data_o, req_addr_i[15:0] ^ 16'ha5c3);
        end
        step(8);
    endtask

    // single-byte reads on a wide device: enables follow the request
    task automatic t_lane;
        req_be_n_i = 2'h2;
        cyc(EBU_MEM_RD, 1'b0, 1'b0);
        req_be_n_i = 2'h1;
        cyc(EBU_IO_RD, 1'b0, 1'b0);
        req_be_n_i = 2'h0;
        $display("test lane done");
    endtask

    task automatic t_hold;
        int n;
        hold_i = 1'b1;
        for (n = 0; n < 40 && !bus_grant_out_o; n++) step(1);
        chk("grant", bus_grant_out_o, 1);
        chk("float", bus_oe_n_o, 1);
        step(6);
        chk("held", bus_grant_out_o, 1);
        hold_i = 1'b0;
        for (n = 0; n < 40 && bus_grant_out_o; n++) step(1);
        step(4);
        chk("drive", {bus_grant_out_o, bus_oe_n_o}, 2'h0);
        $display("test hold done");
    endtask

    task automatic print_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog well past the few hundred cycles needed
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end

    initial begin
        step(10);
        nrst_i = 1'b1;
        step(2);
        for (int i = 0; i < 7; i++) cyc(ebu_kind_t'(i), i == 1, 1'b0);
        $display("test kinds done");
        cyc(EBU_MEM_RD, 1'b0, 1'b1);
        $display("test local done");
        t_lane();
        t_hold();
        cyc(EBU_IO_WR, 1'b0, 1'b0);
        $display("test resume done");
        print_verdict();
    end
endmodule // test_external_bus_interface

`default_nettype wire
